// ===== pkg/pdcr_params.svh
// Purpose: constants for the peripheral dma channel register block
// Assumes: byte addresses on the register port, 32-bit data
// Notes: offsets relative to the channel window base
`ifndef PDCR_PARAMS_SVH
`define PDCR_PARAMS_SVH
`define PDCR_ADDR_W 12
`define PDCR_OFF_RX_PTR 12'h0100
`define PDCR_OFF_RX_CNT 12'h0104
`define PDCR_OFF_TX_PTR 12'h0108
`define PDCR_OFF_TX_CNT 12'h010C
`define PDCR_OFF_RX_NPTR 12'h0110
`define PDCR_OFF_RX_NCNT 12'h0114
`define PDCR_OFF_TX_NPTR 12'h0118
`define PDCR_OFF_TX_NCNT 12'h011C
`define PDCR_OFF_CTRL 12'h0120
`define PDCR_OFF_STAT 12'h0124
`define PDCR_OFF_FLAGS 12'h0128
`define PDCR_BIT_RX_EN 0
`define PDCR_BIT_RX_DIS 1
`define PDCR_BIT_TX_EN 8
`define PDCR_BIT_TX_DIS 9
`define PDCR_BIT_RX_DONE 0
`define PDCR_BIT_RX_FULL 1
`define PDCR_BIT_TX_DONE 2
`define PDCR_BIT_TX_EMPTY 3
`define PDCR_RST_PTR 32'h0000_0000
`define PDCR_RST_CNT 16'h0000
`define PDCR_ZERO32 32'h0000_0000
`define PDCR_CNT_ONE 16'h0001
`define PDCR_SIZE_BYTE 2'h0
`define PDCR_SIZE_HALF 2'h1
`define PDCR_SIZE_WORD 2'h2
`define PDCR_STEP_BYTE 32'h0000_0001
`define PDCR_STEP_HALF 32'h0000_0002
`define PDCR_STEP_WORD 32'h0000_0004
`endif

// ===== pkg/pdcr_pkg.sv
// Purpose: types for the peripheral dma channel register block
// Assumes: nothing
// Notes: bus request carried as a struct; the read answer is a plain 32-bit word
package pdcr_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pdcr_bus_req_t;
   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] cnt;
   } pdcr_seg_t;
   typedef struct packed {
      logic rx_segment_done;
      logic rx_all_buffers_full;
      logic tx_segment_done;
      logic tx_all_buffers_empty;
   } pdcr_flags_t;
endpackage : pdcr_pkg

// ===== rtl/pdcr_channel.sv
// Purpose: register file and request control of a peripheral dma channel pair
// Assumes: one item moved per i_rx_item_done / i_tx_item_done pulse
// Notes: half duplex strap folds rx and tx onto one register set
//
// Behaviour
// [R1] rx count zero halts rx movement; nonzero moves when rx enabled
// [R2] tx count zero halts tx movement; nonzero moves when tx enabled
// [R3] software loads rx address and item count
// [R4] software loads tx address and item count
// [R5] half duplex: one shared current pointer for both directions
// [R6] half duplex: one shared current count for both directions
// [R7] rx following pointer and count hold next buffer; shared in half duplex
// [R8] tx following pointer and count hold next tx buffer
// [R9] control bit 0 enables rx unless bit 1 set too
// [R10] control bit 1 disables rx requests
// [R11] control bit 8 enables tx requests
// [R12] control bit 9 disables tx requests
// [R13] half duplex: rx enable turns tx off
// [R14] half duplex: tx enable only acts without rx enable
// [R15] software never sets both enables in half duplex
// [R16] half duplex: rx disable also turns tx off
// [R17] half duplex: tx disable also turns rx off
// [R18] status bit 0 shows rx request enable
// [R19] status bit 8 shows tx request enable
// [R20] count zero with following nonzero reloads current, clears following
// [R21] segment done and all buffers flags raised from counts
// [R22] pointer advances by 1, 2 or 4 per item
// [R23] reserved bits read zero, writes ignored
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "pdcr_params.svh"
module pdcr_channel (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic i_half_duplex,
   input wire pdcr_pkg::pdcr_bus_req_t i_bus,
   output logic [31:0] o_rdata,
   input wire logic [1:0] i_item_size,
   input wire logic i_rx_item_done,
   input wire logic i_tx_item_done,
   output logic o_rx_request_go,
   output logic o_tx_request_go,
   output logic [31:0] o_rx_addr,
   output logic [31:0] o_tx_addr,
   output pdcr_pkg::pdcr_flags_t o_flags
);
   import pdcr_pkg::*;

   // =====================================================================
   // helpers
   function automatic logic [31:0] step_of(input logic [1:0] size);
      logic [31:0] s;
      s = `PDCR_STEP_WORD;
      if (size == `PDCR_SIZE_BYTE) begin
         s = `PDCR_STEP_BYTE;
      end else if (size == `PDCR_SIZE_HALF) begin
         s = `PDCR_STEP_HALF;
      end
      return s;
   endfunction : step_of

   // write strobe aimed at one register offset
   function automatic logic wr_hit(input pdcr_bus_req_t req, input logic [11:0] off);
      return req.wr && req.addr == off;
   endfunction : wr_hit

   // a count that still holds items to move
   function automatic logic cnt_live(input logic [15:0] cnt);
      return cnt != `PDCR_RST_CNT;
   endfunction : cnt_live

   // current segment after one item, with reload from following
   function automatic pdcr_seg_t advance(input pdcr_seg_t cur, input pdcr_seg_t fol,
                                         input logic [31:0] step, output logic reload);
      pdcr_seg_t r;
      r.addr = cur.addr + step;
      r.cnt = cur.cnt - `PDCR_CNT_ONE;
      reload = 1'b0;
      if (!cnt_live(r.cnt) && cnt_live(fol.cnt)) begin
         r = fol;
         reload = 1'b1;
      end
      return r;
   endfunction : advance

   // =====================================================================
   // state
   pdcr_seg_t rx_cur;
   pdcr_seg_t tx_cur_own;
   pdcr_seg_t rx_fol;
   pdcr_seg_t tx_fol_own;
   logic rx_request_enable;
   logic tx_request_enable;
   pdcr_flags_t flags;

   // =====================================================================
   // half duplex view: tx aliases onto rx storage
   pdcr_seg_t tx_cur;
   pdcr_seg_t tx_fol;
   assign tx_cur = i_half_duplex ? rx_cur : tx_cur_own; // R5 R6
   assign tx_fol = i_half_duplex ? rx_fol : tx_fol_own; // R7

   // =====================================================================
   // decode
   wire wr_rx_ptr = wr_hit(i_bus, `PDCR_OFF_RX_PTR);
   wire wr_rx_cnt = wr_hit(i_bus, `PDCR_OFF_RX_CNT);
   wire wr_tx_ptr = wr_hit(i_bus, `PDCR_OFF_TX_PTR);
   wire wr_tx_cnt = wr_hit(i_bus, `PDCR_OFF_TX_CNT);
   wire wr_rx_nptr = wr_hit(i_bus, `PDCR_OFF_RX_NPTR);
   wire wr_rx_ncnt = wr_hit(i_bus, `PDCR_OFF_RX_NCNT);
   wire wr_tx_nptr = wr_hit(i_bus, `PDCR_OFF_TX_NPTR);
   wire wr_tx_ncnt = wr_hit(i_bus, `PDCR_OFF_TX_NCNT);
   wire wr_ctrl = wr_hit(i_bus, `PDCR_OFF_CTRL);
   // count writes keep the low half; upper bits are reserved
   wire [15:0] wcnt = i_bus.wdata[15:0]; // R23

   // half duplex writes to either name land in the shared set
   wire hd_cur_ptr_wr = wr_rx_ptr || (i_half_duplex && wr_tx_ptr);
   wire hd_cur_cnt_wr = wr_rx_cnt || (i_half_duplex && wr_tx_cnt);
   wire hd_fol_ptr_wr = wr_rx_nptr || (i_half_duplex && wr_tx_nptr);
   wire hd_fol_cnt_wr = wr_rx_ncnt || (i_half_duplex && wr_tx_ncnt);

   // =====================================================================
   // request control
   wire c_rx_en = wr_ctrl && i_bus.wdata[`PDCR_BIT_RX_EN];
   wire c_rx_dis = wr_ctrl && i_bus.wdata[`PDCR_BIT_RX_DIS];
   wire c_tx_en = wr_ctrl && i_bus.wdata[`PDCR_BIT_TX_EN];
   wire c_tx_dis = wr_ctrl && i_bus.wdata[`PDCR_BIT_TX_DIS];
   logic next_rx_request_enable;
   logic next_tx_request_enable;
   always_comb begin
      next_rx_request_enable = rx_request_enable;
      next_tx_request_enable = tx_request_enable;
      // one shared channel: at most one direction may request
      if (i_half_duplex) begin
         if (c_rx_dis || c_tx_dis) begin
            next_rx_request_enable = 1'b0; // R16 R17
            next_tx_request_enable = 1'b0; // R16 R17
         end else if (c_rx_en) begin
            next_rx_request_enable = 1'b1; // R9
            next_tx_request_enable = 1'b0; // R13 R14 R15
         end else if (c_tx_en) begin
            next_tx_request_enable = 1'b1; // R14
            next_rx_request_enable = 1'b0;
         end
      end else begin
         if (c_rx_dis) begin
            next_rx_request_enable = 1'b0; // R10
         end else if (c_rx_en) begin
            next_rx_request_enable = 1'b1; // R9
         end
         if (c_tx_dis) begin
            next_tx_request_enable = 1'b0; // R12
         end else if (c_tx_en) begin
            next_tx_request_enable = 1'b1; // R11
         end
      end
   end

   // =====================================================================
   // transfer advance
   wire rx_go = rx_request_enable && cnt_live(rx_cur.cnt); // R1
   wire tx_go = tx_request_enable && cnt_live(tx_cur.cnt); // R2
   wire [31:0] step = step_of(i_item_size);
   wire rx_move = rx_go && i_rx_item_done;
   wire tx_move = tx_go && i_tx_item_done;
   pdcr_seg_t rx_adv;
   pdcr_seg_t tx_adv;
   logic rx_reload;
   logic tx_reload;
   always_comb begin
      rx_adv = advance(rx_cur, rx_fol, step, rx_reload); // R20 R22
      tx_adv = advance(tx_cur, tx_fol, step, tx_reload); // R20 R22
   end

   // one mover for the shared set in half duplex
   // a same-cycle tie between the two directions goes to rx
   wire hd_move = i_half_duplex ? (rx_move || tx_move) : rx_move;
   wire hd_reload = i_half_duplex ? (rx_move ? rx_reload : tx_reload) : rx_reload;
   pdcr_seg_t hd_adv;
   assign hd_adv = (i_half_duplex && !rx_move) ? tx_adv : rx_adv;

   // =====================================================================
   // next values of the register sets
   pdcr_seg_t next_rx_cur;
   pdcr_seg_t next_rx_fol;
   pdcr_seg_t next_tx_cur_own;
   pdcr_seg_t next_tx_fol_own;
   always_comb begin
      next_rx_cur = rx_cur;
      next_rx_fol = rx_fol;
      if (hd_move) begin
         next_rx_cur = hd_adv;
         if (hd_reload) begin
            next_rx_fol = '0; // R20
         end
      end
      // software writes win over the advance
      if (hd_cur_ptr_wr) begin
         next_rx_cur.addr = i_bus.wdata; // R3 R5
      end
      if (hd_cur_cnt_wr) begin
         next_rx_cur.cnt = wcnt; // R3 R6
      end
      if (hd_fol_ptr_wr) begin
         next_rx_fol.addr = i_bus.wdata; // R7
      end
      if (hd_fol_cnt_wr) begin
         next_rx_fol.cnt = wcnt; // R7
      end
   end

   always_comb begin
      next_tx_cur_own = tx_cur_own;
      next_tx_fol_own = tx_fol_own;
      if (tx_move && !i_half_duplex) begin
         next_tx_cur_own = tx_adv;
         if (tx_reload) begin
            next_tx_fol_own = '0; // R20
         end
      end
      if (wr_tx_ptr && !i_half_duplex) begin
         next_tx_cur_own.addr = i_bus.wdata; // R4
      end
      if (wr_tx_cnt && !i_half_duplex) begin
         next_tx_cur_own.cnt = wcnt; // R4
      end
      if (wr_tx_nptr && !i_half_duplex) begin
         next_tx_fol_own.addr = i_bus.wdata; // R8
      end
      if (wr_tx_ncnt && !i_half_duplex) begin
         next_tx_fol_own.cnt = wcnt; // R8
      end
   end

   // =====================================================================
   // flags: set by end of segment, cleared by nonzero count writes
   wire rx_cnt_nz_wr = (hd_cur_cnt_wr || hd_fol_cnt_wr) && cnt_live(wcnt);
   // shared set in half duplex: a nonzero count write clears both directions
   wire tx_cnt_nz_wr = i_half_duplex ? rx_cnt_nz_wr
                     : (wr_tx_cnt || wr_tx_ncnt) && cnt_live(wcnt);
   wire rx_end = rx_move && !cnt_live(rx_adv.cnt);
   wire tx_end = tx_move && !cnt_live(tx_adv.cnt);
   wire rx_seg_end = rx_move && (rx_reload || !cnt_live(rx_adv.cnt));
   wire tx_seg_end = tx_move && (tx_reload || !cnt_live(tx_adv.cnt));
   pdcr_flags_t next_flags;
   always_comb begin
      next_flags = flags;
      if (rx_cnt_nz_wr) begin
         next_flags.rx_segment_done = 1'b0;
         next_flags.rx_all_buffers_full = 1'b0;
      end
      if (tx_cnt_nz_wr) begin
         next_flags.tx_segment_done = 1'b0;
         next_flags.tx_all_buffers_empty = 1'b0;
      end
      // set wins over clear
      if (rx_seg_end) begin
         next_flags.rx_segment_done = 1'b1; // R21
      end
      if (rx_end) begin
         next_flags.rx_all_buffers_full = 1'b1; // R21
      end
      if (tx_seg_end) begin
         next_flags.tx_segment_done = 1'b1; // R21
      end
      if (tx_end) begin
         next_flags.tx_all_buffers_empty = 1'b1; // R21
      end
   end

   // =====================================================================
   // registers
   // rx set, which is the shared set in half duplex
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_cur <= '0;
         rx_fol <= '0;
      end else begin
         rx_cur <= next_rx_cur;
         rx_fol <= next_rx_fol;
      end
   end

   // own tx set, frozen while half duplex
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         tx_cur_own <= '0;
         tx_fol_own <= '0;
      end else begin
         tx_cur_own <= next_tx_cur_own;
         tx_fol_own <= next_tx_fol_own;
      end
   end

   // request enables
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         rx_request_enable <= 1'b0;
         tx_request_enable <= 1'b0;
      end else begin
         rx_request_enable <= next_rx_request_enable;
         tx_request_enable <= next_tx_request_enable;
      end
   end

   // event flags
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

   // =====================================================================
   // read path
   logic [31:0] status_word;
   logic [31:0] flag_word;
   always_comb begin
      status_word = `PDCR_ZERO32;
      status_word[`PDCR_BIT_RX_EN] = rx_request_enable; // R18
      status_word[`PDCR_BIT_TX_EN] = tx_request_enable; // R19
      flag_word = `PDCR_ZERO32;
      flag_word[`PDCR_BIT_RX_DONE] = flags.rx_segment_done;
      flag_word[`PDCR_BIT_RX_FULL] = flags.rx_all_buffers_full;
      flag_word[`PDCR_BIT_TX_DONE] = flags.tx_segment_done;
      flag_word[`PDCR_BIT_TX_EMPTY] = flags.tx_all_buffers_empty;
   end

   // tx names read the shared set in half duplex
   logic [31:0] rd_mux;
   always_comb begin
      if (i_bus.addr == `PDCR_OFF_RX_PTR) begin
         rd_mux = rx_cur.addr;
      end else if (i_bus.addr == `PDCR_OFF_RX_CNT) begin
         rd_mux = {16'h0000, rx_cur.cnt}; // R23
      end else if (i_bus.addr == `PDCR_OFF_TX_PTR) begin
         rd_mux = tx_cur.addr;
      end else if (i_bus.addr == `PDCR_OFF_TX_CNT) begin
         rd_mux = {16'h0000, tx_cur.cnt}; // R23
      end else if (i_bus.addr == `PDCR_OFF_RX_NPTR) begin
         rd_mux = rx_fol.addr;
      end else if (i_bus.addr == `PDCR_OFF_RX_NCNT) begin
         rd_mux = {16'h0000, rx_fol.cnt};
      end else if (i_bus.addr == `PDCR_OFF_TX_NPTR) begin
         rd_mux = tx_fol.addr;
      end else if (i_bus.addr == `PDCR_OFF_TX_NCNT) begin
         rd_mux = {16'h0000, tx_fol.cnt};
      end else if (i_bus.addr == `PDCR_OFF_STAT) begin
         rd_mux = status_word;
      end else if (i_bus.addr == `PDCR_OFF_FLAGS) begin
         rd_mux = flag_word;
      end else begin
         // control register is write only; unmapped reads zero
         rd_mux = `PDCR_ZERO32;
      end
   end

   // zero outside the answer cycle, so no stale word lingers on the port
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         o_rdata <= `PDCR_ZERO32;
      end else if (i_bus.rd) begin
         o_rdata <= rd_mux;
      end else begin
         o_rdata <= `PDCR_ZERO32;
      end
   end

   // =====================================================================
   // outputs
   assign o_rx_request_go = rx_go;
   assign o_tx_request_go = tx_go;
   assign o_rx_addr = rx_cur.addr;
   assign o_tx_addr = tx_cur.addr;
   assign o_flags = flags;

endmodule : pdcr_channel

// ===== dv/pdcr_channel_sva.sv
// Purpose: port checks for pdcr_channel
// Assumes: pdcr_pkg compiled first
// Notes: bound to every pdcr_channel
`timescale 1ns/1ps
`include "pdcr_params.svh"
module pdcr_channel_sva (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic i_half_duplex,
   input wire pdcr_pkg::pdcr_bus_req_t i_bus,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] i_item_size,
   input wire logic i_rx_item_done,
   input wire logic i_tx_item_done,
   input wire logic o_rx_request_go,
   input wire logic o_tx_request_go,
   input wire logic [31:0] o_rx_addr,
   input wire logic [31:0] o_tx_addr,
   input wire pdcr_pkg::pdcr_flags_t o_flags
);
   import pdcr_pkg::*;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);
   wire ctl_wr = i_bus.wr && i_bus.addr == `PDCR_OFF_CTRL;
   wire st_rd = i_bus.rd && i_bus.addr == `PDCR_OFF_STAT;
   wire hd_en = i_half_duplex && ctl_wr;
   wire [31:0] step = (i_item_size == `PDCR_SIZE_BYTE) ? `PDCR_STEP_BYTE :
      (i_item_size == `PDCR_SIZE_HALF) ? `PDCR_STEP_HALF : `PDCR_STEP_WORD;
   // ==========
   // last rx item empties both counts
   sequence s_rx_last;
      i_rx_item_done && !i_bus.wr && !i_half_duplex ##1 $fell(o_rx_request_go);
   endsequence
   rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == `PDCR_ZERO32)
      else $error("read data outside read cycle");
   stat_rsvd_a: assert property (st_rd |=> (o_rdata & 32'hFFFF_FEFE) == 0)
      else $error("status reserved bits set");
   ctrl_read_a: assert property (i_bus.rd && i_bus.addr == `PDCR_OFF_CTRL |=> o_rdata == 0)
      else $error("control read not zero");
   stat_rx_a: assert property (st_rd && o_rx_request_go |=> o_rdata[0])
      else $error("rx enable not shown");
   stat_tx_a: assert property (st_rd && o_tx_request_go |=> o_rdata[8])
      else $error("tx enable not shown");
   rx_dis_a: assert property (ctl_wr && i_bus.wdata[1] |=> !o_rx_request_go)
      else $error("rx disable ignored");
   tx_dis_a: assert property (ctl_wr && i_bus.wdata[9] |=> !o_tx_request_go)
      else $error("tx disable ignored");
   hd_dis_a: assert property (hd_en && (i_bus.wdata[1] || i_bus.wdata[9])
      |=> !o_rx_request_go && !o_tx_request_go)
      else $error("half duplex disable left a request");
   hd_rx_en_a: assert property (hd_en && i_bus.wdata[0] && !i_bus.wdata[1]
      && !i_bus.wdata[9] |=> !o_tx_request_go)
      else $error("half duplex rx enable kept tx");
   hd_addr_a: assert property (i_half_duplex |-> o_rx_addr == o_tx_addr)
      else $error("shared pointer differs");
   rx_step_a: assert property (i_rx_item_done && o_rx_request_go && !i_half_duplex
      && !i_bus.wr |=> o_rx_addr == $past(o_rx_addr) + $past(step)
      || o_flags.rx_segment_done)
      else $error("rx pointer step wrong");
   rx_end_a: assert property (s_rx_last |-> o_flags.rx_segment_done
      && o_flags.rx_all_buffers_full)
      else $error("rx end flags missing");
endmodule : pdcr_channel_sva
bind pdcr_channel pdcr_channel_sva i_pdcr_channel_sva (.I_CLK(I_CLK),
   .I_SYS_RST(I_SYS_RST), .i_half_duplex(i_half_duplex), .i_bus(i_bus),
   .o_rdata(o_rdata), .i_item_size(i_item_size), .i_rx_item_done(i_rx_item_done),
   .i_tx_item_done(i_tx_item_done), .o_rx_request_go(o_rx_request_go),
   .o_tx_request_go(o_tx_request_go), .o_rx_addr(o_rx_addr),
   .o_tx_addr(o_tx_addr), .o_flags(o_flags));

// ===== dv/pdcr_periph_model.sv
// Purpose: serial peripheral side, moves one item per done pulse while the request level is high
// Assumes: request level drops one edge after the last item
// Notes: i_gap plus one idle cycles between items, stalls the channel
`timescale 1ns/1ps
module pdcr_periph_model (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_rx_go,
   input wire logic i_tx_go,
   input wire logic [3:0] i_gap,
   output logic o_rx_done,
   output logic o_tx_done
);
   wire [1:0] go = {i_tx_go, i_rx_go};
   logic [1:0] done;
   logic [3:0] wait_cnt [2];
   assign o_rx_done = done[0];
   assign o_tx_done = done[1];
   // one pulse, then at least one idle cycle
   always_ff @(posedge i_clk) begin
      for (int d = 0; d < 2; d++) begin
         if (i_rst || done[d] || !go[d]) begin
            done[d] <= 1'b0;
            wait_cnt[d] <= 4'h0;
         end else if (wait_cnt[d] == i_gap) begin
            done[d] <= 1'b1;
         end else begin
            wait_cnt[d] <= wait_cnt[d] + 4'h1;
         end
      end
   end
endmodule : pdcr_periph_model

// ===== dv/pdcr_channel_tb.sv
// Purpose: self-checking bench for pdcr_channel
// Assumes: register port answers reads one cycle later
// Notes: full duplex first, then half duplex, then a mid-run reset
`timescale 1ns/1ps
`include "pdcr_params.svh"
module pdcr_channel_tb;
   import pdcr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic half = 1'b0;
   logic [1:0] size = 2'h2;
   logic [3:0] gap = 4'h1;
   pdcr_bus_req_t bus = '0;
   logic [31:0] rdata, rx_addr, tx_addr;
   logic rx_go, tx_go, rx_done, tx_done;
   pdcr_flags_t flags;
   int error_cnt = 0;
   int comparisons = 0;
   initial forever #10 clk = ~clk;
   pdcr_channel i_pdcr_channel (.I_CLK(clk), .I_SYS_RST(rst), .i_half_duplex(half),
      .i_bus(bus), .o_rdata(rdata), .i_item_size(size), .i_rx_item_done(rx_done),
      .i_tx_item_done(tx_done), .o_rx_request_go(rx_go), .o_tx_request_go(tx_go),
      .o_rx_addr(rx_addr), .o_tx_addr(tx_addr), .o_flags(flags));
   pdcr_periph_model i_pdcr_periph_model (.i_clk(clk), .i_rst(rst), .i_rx_go(rx_go),
      .i_tx_go(tx_go), .i_gap(gap), .o_rx_done(rx_done), .o_tx_done(tx_done));
   // ==========
   // bus and compare helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 check(rdata, exp);
   endtask : rd
   task automatic ctl(input logic [31:0] w, input logic [31:0] exp);
      wr(`PDCR_OFF_CTRL, w);
      rd(`PDCR_OFF_STAT, exp);
   endtask : ctl
   task automatic complete_run;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : complete_run
   // ==========
   // scenarios
   task automatic t_reset;
      for (int a = 'h100; a <= 'h12C; a += 4) rd(a[11:0], 32'h0000_0000);
   endtask : t_reset
   task automatic t_regs;
      logic [31:0] d;
      for (int i = 0; i < 8; i++) wr(12'h100 + 4 * i, {16'hC3A5, 4'h0, i[3:0], 8'h21});
      for (int i = 0; i < 8; i++) begin
         d = {16'hC3A5, 4'h0, i[3:0], 8'h21};
         rd(12'h100 + 4 * i, i[0] ? {16'h0000, d[15:0]} : d);
      end
      wr(`PDCR_OFF_TX_CNT, 32'h0000_0000);
   endtask : t_regs
   task automatic t_ctrl;
      ctl(32'h0000_0003, 32'h0000_0000);
      ctl(32'h0000_0001, 32'h0000_0001);
      ctl(32'h0000_0000, 32'h0000_0001);
      ctl(32'h0000_0100, 32'h0000_0101);
      ctl(32'h0000_0002, 32'h0000_0100);
      ctl(32'h0000_0200, 32'h0000_0000);
      ctl(32'hFFFF_FCFC, 32'h0000_0000);
   endtask : t_ctrl
   task automatic t_move;
      logic [31:0] st;
      for (int s = 0; s < 3; s++) begin
         st = (s == 0) ? `PDCR_STEP_BYTE : (s == 1) ? `PDCR_STEP_HALF : `PDCR_STEP_WORD;
         @(posedge clk);
         size <= s[1:0];
         gap <= s[3:0];
         wr(`PDCR_OFF_CTRL, 32'h0000_0202);
         wr(`PDCR_OFF_RX_PTR, 32'h2000_0000);
         wr(`PDCR_OFF_RX_CNT, 32'h0000_0001);
         wr(`PDCR_OFF_RX_NPTR, 32'h4000_0100);
         wr(`PDCR_OFF_RX_NCNT, 32'h0000_0002);
         wr(`PDCR_OFF_TX_PTR, 32'h3000_0000);
         wr(`PDCR_OFF_TX_NCNT, 32'h0000_0000);
         wr(`PDCR_OFF_TX_CNT, 32'h0000_0002);
         wr(`PDCR_OFF_CTRL, 32'h0000_0101);
         #1 check({30'h0, rx_go, tx_go}, 32'h0000_0003);
         for (int n = 0; n < 200 && (rx_go || tx_go) !== 1'b0; n++) @(posedge clk);
         #1 check(rx_addr, 32'h4000_0100 + 2 * st);
         check(tx_addr, 32'h3000_0000 + 2 * st);
         check({28'h0, flags}, 32'h0000_000F);
         check({30'h0, rx_go, tx_go}, 32'h0000_0000);
         rd(`PDCR_OFF_RX_NCNT, 32'h0000_0000);
         rd(`PDCR_OFF_RX_NPTR, 32'h0000_0000);
         rd(`PDCR_OFF_STAT, 32'h0000_0101);
      end
   endtask : t_move
   task automatic t_half;
      @(posedge clk);
      half <= 1'b1;
      wr(`PDCR_OFF_CTRL, 32'h0000_0202);
      wr(`PDCR_OFF_RX_PTR, 32'h1234_5678);
      rd(`PDCR_OFF_TX_PTR, 32'h1234_5678);
      check(tx_addr, 32'h1234_5678);
      wr(`PDCR_OFF_TX_CNT, 32'h0000_0009);
      rd(`PDCR_OFF_RX_CNT, 32'h0000_0009);
      wr(`PDCR_OFF_TX_NPTR, 32'h5555_AAA0);
      rd(`PDCR_OFF_RX_NPTR, 32'h5555_AAA0);
      wr(`PDCR_OFF_RX_NCNT, 32'h0000_0004);
      rd(`PDCR_OFF_TX_NCNT, 32'h0000_0004);
      ctl(32'h0000_0100, 32'h0000_0100);
      ctl(32'h0000_0001, 32'h0000_0001);
      ctl(32'h0000_0200, 32'h0000_0000);
      ctl(32'h0000_0100, 32'h0000_0100);
      ctl(32'h0000_0002, 32'h0000_0000);
   endtask : t_half
   task automatic t_rerst;
      wr(`PDCR_OFF_CTRL, 32'h0000_0001);
      #1 check({31'h0, rx_go}, 32'h0000_0001);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1 check({30'h0, rx_go, tx_go}, 32'h0000_0000);
      t_reset();
   endtask : t_rerst
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_ctrl();
      t_move();
      t_half();
      t_rerst();
      complete_run();
   end
   initial begin
      #400_000;
      error_cnt++;
      complete_run();
   end
endmodule : pdcr_channel_tb
